// >>> pwr_pkg.sv
// Shared constants and types for the power control and low-power mode block.
package pwr_pkg;

    // Register map.
    localparam logic [7:0] SUPPLY_MONITOR_CTRL_STATUS_ADDR = 8'h00;
    localparam logic [7:0] REFERENCE_CTRL_STATUS_ADDR      = 8'h01;
    localparam logic [7:0] REG_RESET                       = 8'h00;

    // Fields of the supply monitor register.
    localparam int DETECTOR_ON_BIT    = 0;
    localparam int LEVEL_LO_BIT       = 1;
    localparam int LEVEL_HI_BIT       = 3;
    localparam int IRQ_ENABLE_BIT     = 4;
    localparam int EVENT_FLAG_BIT     = 5;
    localparam int OUTPUT_STATE_BIT   = 6;

    // Fields of the reference register.
    localparam int REF_READY_BIT      = 0;
    localparam int LOW_LEAKAGE_BIT    = 1;
    localparam int FAST_WAKEUP_BIT    = 2;

    localparam logic [2:0] LEVEL_EXTERNAL = 3'h7;

    // Fast wakeup time and its cycle count at 100 MHz, rounded up.
    localparam int CLK_PERIOD_PS      = 10_000;
    localparam int FAST_WAKE_NS       = 6_000;
    localparam int FAST_WAKE_CYCLES   = (FAST_WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WAKE_CNT_W         = 10;

    typedef enum logic [2:0] {
        MODE_RUN        = 3'b000,
        MODE_WAIT_INT   = 3'b001,
        MODE_WAIT_EVT   = 3'b010,
        MODE_LP_RUN     = 3'b011,
        MODE_LP_WAIT    = 3'b100,
        MODE_ACT_HALT   = 3'b101,
        MODE_HALT       = 3'b110,
        MODE_WAKING     = 3'b111
    } power_mode_type;

    // Instruction and wakeup inputs from the CPU and the system.
    typedef struct packed {
        logic wait_interrupt_instr;
        logic wait_event_instr;
        logic halt_instr;
        logic lp_run_enter;
        logic lp_run_exit;
    } cpu_request_type;

    typedef struct packed {
        logic interrupt_any;
        logic wakeup_event;
        logic external_irq;
        logic rtc_irq;
    } wake_source_type;

    // Clock and supply controls driven toward the analog and clock blocks.
    typedef struct packed {
        logic main_regulator_mode;
        logic cpu_clock_on;
        logic periph_clock_on;
        logic fast_osc_on;
        logic slow_osc_on;
        logic flash_on;
        logic reference_on;
    } power_ctrl_type;

endpackage

// >>> pwr_detector_edge.sv
// Event generator for the supply threshold detector output.
`timescale 1ns/10ps
`default_nettype none
module pwr_detector_edge
    import pwr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic level,
    output logic      event_pulse
);
    logic prev;

    always_ff @(posedge clk) begin
        if (rst) begin
            prev <= 1'b0;
        end else begin
            prev <= enable & level;
        end
    end

    assign event_pulse = (enable & level) != prev;

    a_edge_event: assert property (@(posedge clk) disable iff (rst)
        ($changed(enable & level)) |-> event_pulse) else $error("detector change without event");
endmodule
`default_nettype wire

// >>> pwr_mode_ctrl.sv
// Low-power mode state machine with regulator and clock controls.
`timescale 1ns/10ps
`default_nettype none
module pwr_mode_ctrl
    import pwr_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire pwr_pkg::cpu_request_type req,
    input  wire pwr_pkg::wake_source_type wake,
    input  wire logic            detector_irq,
    input  wire logic            halt_uses_main,
    input  wire logic            low_leakage_regulator,
    input  wire logic            fast_wakeup_select,
    input  wire logic            reference_ready,
    output pwr_pkg::power_mode_type  mode,
    output pwr_pkg::power_ctrl_type  ctrl
);
    import pwr_pkg::*;

    power_mode_type       next_mode;
    logic [WAKE_CNT_W-1:0] wake_cnt;
    logic                 halt_wake;
    logic                 act_halt_wake;
    logic                 wake_done;

    assign halt_wake     = wake.external_irq | detector_irq;
    assign act_halt_wake = wake.external_irq | wake.rtc_irq | detector_irq;
    // skip reference wait on fast wakeup
    assign wake_done = (wake_cnt == WAKE_CNT_W'(FAST_WAKE_CYCLES - 1))
                       && (fast_wakeup_select || !low_leakage_regulator || reference_ready);

    always_comb begin
        next_mode = mode;
        case (mode)
            MODE_RUN: begin
                if (req.wait_interrupt_instr) begin
                    next_mode = MODE_WAIT_INT;
                end else if (req.wait_event_instr) begin
                    next_mode = MODE_WAIT_EVT;
                end else if (req.halt_instr) begin
                    next_mode = halt_uses_main ? MODE_ACT_HALT : MODE_HALT;
                end else if (req.lp_run_enter) begin
                    next_mode = MODE_LP_RUN;
                end
            end
            MODE_WAIT_INT: if (wake.interrupt_any) next_mode = MODE_RUN;
            MODE_WAIT_EVT: if (wake.interrupt_any || wake.wakeup_event) next_mode = MODE_RUN;
            // interrupts cannot end low power run or low power wait
            MODE_LP_RUN: begin
                if (req.lp_run_exit) begin
                    next_mode = MODE_RUN;
                end else if (req.wait_event_instr) begin
                    next_mode = MODE_LP_WAIT;
                end
            end
            // event returns to low power run
            MODE_LP_WAIT: if (wake.wakeup_event) next_mode = MODE_LP_RUN;
            MODE_ACT_HALT: if (act_halt_wake) next_mode = MODE_WAKING;
            MODE_HALT: if (halt_wake) next_mode = MODE_WAKING;
            MODE_WAKING: if (wake_done) next_mode = MODE_RUN;
            default: next_mode = MODE_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= MODE_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || mode != MODE_WAKING) begin
            wake_cnt <= '0;
        end else if (wake_cnt != WAKE_CNT_W'(FAST_WAKE_CYCLES - 1)) begin
            wake_cnt <= wake_cnt + 1'b1;
        end
    end

    // Activity controls follow the mode; a wait holds the cpu clock off until exit.
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= '{main_regulator_mode: 1'b1, cpu_clock_on: 1'b1, periph_clock_on: 1'b1,
                      fast_osc_on: 1'b1, slow_osc_on: 1'b1, flash_on: 1'b1, reference_on: 1'b1};
        end else begin
            // main regulator in run, both wait sleeps, waking and active-halt when halt_uses_main
            ctrl.main_regulator_mode <= (next_mode == MODE_RUN) || (next_mode == MODE_WAIT_INT)
                                        || (next_mode == MODE_WAIT_EVT) || (next_mode == MODE_WAKING)
                                        || (next_mode == MODE_ACT_HALT && halt_uses_main);
            // only cpu clock stops in wait
            ctrl.cpu_clock_on    <= (next_mode == MODE_RUN) || (next_mode == MODE_LP_RUN);
            ctrl.periph_clock_on <= (next_mode != MODE_HALT) && (next_mode != MODE_ACT_HALT);
            // low power run uses slow clock, flash off
            ctrl.fast_osc_on     <= (next_mode == MODE_RUN) || (next_mode == MODE_WAIT_INT)
                                    || (next_mode == MODE_WAIT_EVT) || (next_mode == MODE_WAKING);
            ctrl.slow_osc_on     <= (next_mode != MODE_HALT);
            ctrl.flash_on        <= (next_mode != MODE_LP_RUN) && (next_mode != MODE_LP_WAIT)
                                    && (next_mode != MODE_HALT) && (next_mode != MODE_ACT_HALT);
            // reference stopped in halts when low leakage is set
            ctrl.reference_on    <= !(low_leakage_regulator
                                      && (next_mode == MODE_HALT || next_mode == MODE_ACT_HALT));
        end
    end

    a_halt_regulator: assert property (@(posedge clk) disable iff (rst)
        (mode == MODE_HALT) |-> !ctrl.main_regulator_mode) else $error("main regulator in halt");
    a_wait_no_irq_exit: assert property (@(posedge clk) disable iff (rst)
        (mode == MODE_LP_WAIT && !wake.wakeup_event) |=> (mode == MODE_LP_WAIT)) else $error("lp wait left");
    // The wakeup delay is checked against the counter, one cycle at a time, so no long repetition is needed.
    a_fast_wake_hold: assert property (@(posedge clk) disable iff (rst)
        (mode == MODE_WAKING && wake_cnt != WAKE_CNT_W'(FAST_WAKE_CYCLES - 1)) |=> (mode == MODE_WAKING))
        else $error("wakeup left early");
    a_fast_wake_time: assert property (@(posedge clk) disable iff (rst)
        (mode == MODE_WAKING && wake_cnt == WAKE_CNT_W'(FAST_WAKE_CYCLES - 1) && fast_wakeup_select)
        |=> (mode == MODE_RUN))
        else $error("fast wakeup not 6 us");
endmodule
`default_nettype wire

// >>> pwr_control.sv
// Power control unit: detector and reference registers plus low-power mode control.
// Behaviour
// - Main regulator used in run and both wait sleeps, switched automatically.
// - Halt uses low-power regulator; active-halt follows clock-controller setting.
// - Detector event sets flag bit 5; write one clears, zero ignored.
// - Bit 6 reads live detector output, one when detector on and supply below threshold.
// - Bit 4 gates the detector interrupt request from the flag.
// - Bits 3:1 pick seven levels; code 111 selects external input.
// - Bit 0 turns the detector on when one, off when zero.
// - Detector interrupt wakes halt and active-halt, not the wait modes.
// - Reference bit 0 reads one when reference on and stable.
// - Both registers read zero after reset, except reference bit 0 when stable.
// - Reset starts in run with cpu clocked and main regulator.
// - Wait stops cpu clock only; interrupts, and events for event-wait, exit.
// - Low power run uses slow clock, flash off, low-power regulator.
// - Event-wait in low power run enters low power wait; event returns.
// - Active-halt stops most clocks; wakes on rtc, external interrupt, reset.
// - Halt wakes only on external or detector interrupt; fast wakeup takes 6 us.
// - Low-leakage stops reference in halts; fast wakeup skips its startup.
// - Detector output change in either direction is an event.
`timescale 1ns/10ps
`default_nettype none
module pwr_control
    import pwr_pkg::*;
(
    input  wire logic                CLK,
    input  wire logic                RST,
    input  wire logic [7:0]          ADDR,
    input  wire logic [7:0]          WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    output logic      [7:0]          RDATA,
    input  wire logic                DETECTOR_BELOW,
    input  wire logic                REFERENCE_STABLE,
    input  wire logic                HALT_USES_MAIN,
    input  wire pwr_pkg::cpu_request_type CPU_REQ,
    input  wire pwr_pkg::wake_source_type WAKE,
    output logic                     DETECTOR_IRQ,
    output logic                     DETECTOR_ENABLE,
    output logic      [2:0]          DETECTOR_LEVEL,
    output logic                     EXTERNAL_THRESHOLD_INPUT_SEL,
    output pwr_pkg::power_mode_type  MODE,
    output pwr_pkg::power_ctrl_type  CTRL
);
    import pwr_pkg::*;

    logic       detector_on;
    logic [2:0] detector_level_select;
    logic       detector_irq_enable;
    logic       detector_event_flag;
    logic       detector_output_state;
    logic       fast_wakeup_select;
    logic       low_leakage_regulator;
    logic       reference_ready;
    logic       detector_event;
    logic       wr_monitor;
    logic       wr_reference;

    assign wr_monitor   = WR && (ADDR == SUPPLY_MONITOR_CTRL_STATUS_ADDR);
    assign wr_reference = WR && (ADDR == REFERENCE_CTRL_STATUS_ADDR);

    // The output reads zero while the detector is switched off.
    // live detector output
    assign detector_output_state = detector_on & DETECTOR_BELOW;
    assign reference_ready = REFERENCE_STABLE & CTRL.reference_on;

    pwr_detector_edge u_edge (
        .clk         (CLK),
        .rst         (RST),
        .enable      (detector_on),
        .level       (DETECTOR_BELOW),
        .event_pulse (detector_event)
    );

    // Enable is plain read/write, since software must be able to turn it on.
    // detector enable, level select and interrupt enable
    always_ff @(posedge CLK) begin
        if (RST) begin
            detector_on           <= REG_RESET[DETECTOR_ON_BIT];
            detector_level_select <= REG_RESET[LEVEL_HI_BIT:LEVEL_LO_BIT];
            detector_irq_enable   <= REG_RESET[IRQ_ENABLE_BIT];
        end else if (wr_monitor) begin
            detector_on           <= WDATA[DETECTOR_ON_BIT];
            detector_level_select <= WDATA[LEVEL_HI_BIT:LEVEL_LO_BIT];
            detector_irq_enable   <= WDATA[IRQ_ENABLE_BIT];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            detector_event_flag <= REG_RESET[EVENT_FLAG_BIT];
        end else if (detector_event) begin
            detector_event_flag <= 1'b1;
        end else if (wr_monitor && WDATA[EVENT_FLAG_BIT]) begin
            detector_event_flag <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            fast_wakeup_select    <= REG_RESET[FAST_WAKEUP_BIT];
            low_leakage_regulator <= REG_RESET[LOW_LEAKAGE_BIT];
        end else if (wr_reference) begin
            fast_wakeup_select    <= WDATA[FAST_WAKEUP_BIT];
            low_leakage_regulator <= WDATA[LOW_LEAKAGE_BIT];
        end
    end

    // Unmapped addresses and reserved bits read as zero.
    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= REG_RESET;
        end else if (RD) begin
            RDATA <= REG_RESET;
            if (ADDR == SUPPLY_MONITOR_CTRL_STATUS_ADDR) begin
                RDATA[DETECTOR_ON_BIT]            <= detector_on;
                RDATA[LEVEL_HI_BIT:LEVEL_LO_BIT]  <= detector_level_select;
                RDATA[IRQ_ENABLE_BIT]             <= detector_irq_enable;
                RDATA[EVENT_FLAG_BIT]             <= detector_event_flag;
                RDATA[OUTPUT_STATE_BIT]           <= detector_output_state;
            end else if (ADDR == REFERENCE_CTRL_STATUS_ADDR) begin
                RDATA[REF_READY_BIT]              <= reference_ready;
                RDATA[LOW_LEAKAGE_BIT]            <= low_leakage_regulator;
                RDATA[FAST_WAKEUP_BIT]            <= fast_wakeup_select;
            end
        end else begin
            RDATA <= REG_RESET;
        end
    end

    assign DETECTOR_IRQ                 = detector_event_flag & detector_irq_enable;
    assign DETECTOR_ENABLE              = detector_on;
    assign DETECTOR_LEVEL               = detector_level_select;
    assign EXTERNAL_THRESHOLD_INPUT_SEL = detector_on && (detector_level_select == LEVEL_EXTERNAL);

    pwr_mode_ctrl u_mode (
        .clk                   (CLK),
        .rst                   (RST),
        .req                   (CPU_REQ),
        .wake                  (WAKE),
        .detector_irq          (DETECTOR_IRQ),
        .halt_uses_main        (HALT_USES_MAIN),
        .low_leakage_regulator (low_leakage_regulator),
        .fast_wakeup_select    (fast_wakeup_select),
        .reference_ready       (reference_ready),
        .mode                  (MODE),
        .ctrl                  (CTRL)
    );

    a_flag_set_wins: assert property (@(posedge CLK) disable iff (RST)
        detector_event |=> detector_event_flag) else $error("detector event lost");
    a_flag_zero_write: assert property (@(posedge CLK) disable iff (RST)
        (wr_monitor && !WDATA[EVENT_FLAG_BIT] && detector_event_flag) |=> detector_event_flag)
        else $error("flag cleared by zero");
    a_irq_gate: assert property (@(posedge CLK) disable iff (RST)
        DETECTOR_IRQ |-> (detector_irq_enable && detector_event_flag)) else $error("irq not gated");
    a_read_output: assert property (@(posedge CLK) disable iff (RST)
        (RD && ADDR == SUPPLY_MONITOR_CTRL_STATUS_ADDR) |=> (RDATA[OUTPUT_STATE_BIT] == $past(detector_output_state)))
        else $error("output state misread");
    a_reset_run_mode: assert property (@(posedge CLK)
        ($past(RST) && !RST) |-> (MODE == MODE_RUN && CTRL.main_regulator_mode && CTRL.cpu_clock_on))
        else $error("not run after reset");
    a_wait_regulator: assert property (@(posedge CLK) disable iff (RST)
        (MODE == MODE_WAIT_INT || MODE == MODE_WAIT_EVT) |-> CTRL.main_regulator_mode)
        else $error("wait without main regulator");
    a_level_write: assert property (@(posedge CLK) disable iff (RST)
        wr_monitor |=> (DETECTOR_LEVEL == $past(WDATA[LEVEL_HI_BIT:LEVEL_LO_BIT])))
        else $error("level not stored");
    a_lp_run_regulator: assert property (@(posedge CLK) disable iff (RST)
        (MODE == MODE_LP_RUN) |-> (!CTRL.main_regulator_mode && !CTRL.flash_on))
        else $error("lp run regulator or flash");
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the power control unit and its low-power mode controller.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import pwr_pkg::*;
;
    logic            clk;
    logic            rst;
    logic [7:0]      addr;
    logic [7:0]      wdata;
    logic            wr_strobe;
    logic            rd_strobe;
    logic [7:0]      rdata;
    logic            below;
    logic            stable;
    logic            halt_main;
    cpu_request_type cpu_req;
    wake_source_type wake;
    logic            det_irq;
    logic            det_en;
    logic [2:0]      det_level;
    logic            ext_sel;
    power_mode_type  mode;
    power_ctrl_type  ctrl;
    int              errors;
    int              samples_checked;
    int              n;

    pwr_control dut_u (
        .CLK                          (clk),
        .RST                          (rst),
        .ADDR                         (addr),
        .WDATA                        (wdata),
        .WR                           (wr_strobe),
        .RD                           (rd_strobe),
        .RDATA                        (rdata),
        .DETECTOR_BELOW               (below),
        .REFERENCE_STABLE             (stable),
        .HALT_USES_MAIN               (halt_main),
        .CPU_REQ                      (cpu_req),
        .WAKE                         (wake),
        .DETECTOR_IRQ                 (det_irq),
        .DETECTOR_ENABLE              (det_en),
        .DETECTOR_LEVEL               (det_level),
        .EXTERNAL_THRESHOLD_INPUT_SEL (ext_sel),
        .MODE                         (mode),
        .CTRL                         (ctrl)
    );

    always #5 clk = ~clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
    endtask

    task automatic read_reg(input logic [7:0] a, input string what, input logic [7:0] exp);
        logic [7:0] v;
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1 v = rdata;
        check(what, 16'(v), 16'(exp));
    endtask

    // Vector order is wait_interrupt, wait_event, halt, lp_run_enter, lp_run_exit.
    task automatic request(input logic [4:0] v);
        @(posedge clk);
        cpu_req <= cpu_request_type'(v);
        @(posedge clk);
        cpu_req <= '0;
        #1;
    endtask

    // Vector order is interrupt_any, wakeup_event, external_irq, rtc_irq.
    task automatic wake_pulse(input logic [3:0] v);
        @(posedge clk);
        wake <= wake_source_type'(v);
        @(posedge clk);
        wake <= '0;
        #1;
    endtask

    task automatic expect_mode(input power_mode_type m);
        check("mode", 16'(mode), 16'(m));
    endtask

    task automatic wait_mode(input power_mode_type m, input int limit);
        n = 0;
        while (mode !== m && n < limit) begin
            @(posedge clk);
            #1 n++;
        end
    endtask

    initial begin
        #400000;
        errors++;
        complete_run();
    end

    initial begin
        clk = 1'b0; rst = 1'b1; addr = '0; wdata = '0; wr_strobe = 1'b0; rd_strobe = 1'b0;
        below = 1'b0; stable = 1'b0; halt_main = 1'b0; cpu_req = '0; wake = '0;
        errors = 0; samples_checked = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        expect_mode(MODE_RUN);
        check("main_regulator", 16'(ctrl.main_regulator_mode), 16'h0001);
        check("cpu_clock", 16'(ctrl.cpu_clock_on), 16'h0001);
        read_reg(SUPPLY_MONITOR_CTRL_STATUS_ADDR, "monitor_reset", REG_RESET);
        read_reg(REFERENCE_CTRL_STATUS_ADDR, "reference_reset", REG_RESET);
        for (int i = 0; i < 8; i++) begin
            write_reg(8'h00, {4'h0, 3'(i), 1'b1});
            #1;
            check("level", 16'(det_level), 16'(i));
            check("external_select", 16'(ext_sel), 16'(i == 7));
            check("detector_on", 16'(det_en), 16'h0001);
            read_reg(8'h00, "level_readback", {4'h0, 3'(i), 1'b1});
        end
        write_reg(8'h00, 8'h11);
        @(posedge clk);
        below <= 1'b1;
        repeat (3) @(posedge clk);
        read_reg(8'h00, "fall_event", 8'h71);
        check("irq_on", 16'(det_irq), 16'h0001);
        write_reg(8'h00, 8'h11);
        read_reg(8'h00, "zero_no_clear", 8'h71);
        write_reg(8'h00, 8'h31);
        read_reg(8'h00, "one_clears", 8'h51);
        check("irq_off", 16'(det_irq), 16'h0000);
        @(posedge clk);
        below <= 1'b0;
        repeat (3) @(posedge clk);
        read_reg(8'h00, "rise_event", 8'h31);
        write_reg(8'h00, 8'h01);
        #1 check("irq_gated", 16'(det_irq), 16'h0000);
        read_reg(8'h00, "gated_flag_held", 8'h21);
        // A write-one clear that meets a new detector event must leave the flag set.
        fork
            write_reg(8'h00, 8'h31);
            begin
                @(posedge clk);
                below <= 1'b1;
            end
        join
        read_reg(8'h00, "flag_kept", 8'h71);
        write_reg(8'h05, 8'hff);
        read_reg(8'h05, "unmapped", 8'h00);
        read_reg(8'h00, "unmapped_no_effect", 8'h71);
        @(posedge clk);
        stable <= 1'b1;
        write_reg(8'h01, 8'h07);
        read_reg(8'h01, "reference_reserved", 8'h07);
        write_reg(8'h01, 8'h00);
        // Detector interrupt is pending while the wait sleeps run.
        request(5'b10000);
        expect_mode(MODE_WAIT_INT);
        check("wfi_main", 16'(ctrl.main_regulator_mode), 16'h0001);
        check("wfi_cpu", 16'(ctrl.cpu_clock_on), 16'h0000);
        check("wfi_periph", 16'(ctrl.periph_clock_on), 16'h0001);
        wake_pulse(4'b0100);
        expect_mode(MODE_WAIT_INT);
        wake_pulse(4'b1000);
        expect_mode(MODE_RUN);
        request(5'b01000);
        expect_mode(MODE_WAIT_EVT);
        check("wfe_main", 16'(ctrl.main_regulator_mode), 16'h0001);
        wake_pulse(4'b0100);
        expect_mode(MODE_RUN);
        request(5'b00100);
        expect_mode(MODE_HALT);
        check("halt_main", 16'(ctrl.main_regulator_mode), 16'h0000);
        check("halt_cpu", 16'(ctrl.cpu_clock_on), 16'h0000);
        @(posedge clk);
        #1 expect_mode(MODE_WAKING);
        wait_mode(MODE_RUN, 700);
        expect_mode(MODE_RUN);
        write_reg(8'h00, 8'h00);
        write_reg(8'h00, 8'h20);
        read_reg(8'h00, "detector_off", 8'h00);
        write_reg(8'h01, 8'h02);
        read_reg(8'h01, "low_leakage", 8'h03);
        request(5'b00100);
        expect_mode(MODE_HALT);
        check("ref_stopped", 16'(ctrl.reference_on), 16'h0000);
        read_reg(8'h01, "ready_in_halt", 8'h02);
        stable <= 1'b0;
        wake_pulse(4'b0001);
        expect_mode(MODE_HALT);
        wake_pulse(4'b1100);
        expect_mode(MODE_HALT);
        wake_pulse(4'b0010);
        expect_mode(MODE_WAKING);
        repeat (700) @(posedge clk);
        #1 expect_mode(MODE_WAKING);
        stable <= 1'b1;
        wait_mode(MODE_RUN, 20);
        expect_mode(MODE_RUN);
        write_reg(8'h01, 8'h06);
        halt_main <= 1'b1;
        stable <= 1'b0;
        request(5'b00100);
        expect_mode(MODE_ACT_HALT);
        check("act_halt_main", 16'(ctrl.main_regulator_mode), 16'h0001);
        check("act_halt_slow", 16'(ctrl.slow_osc_on), 16'h0001);
        check("act_halt_fast", 16'(ctrl.fast_osc_on), 16'h0000);
        wake_pulse(4'b0001);
        expect_mode(MODE_WAKING);
        wait_mode(MODE_RUN, 700);
        check("fast_wake_cycles", 16'(n), 16'(FAST_WAKE_CYCLES));
        expect_mode(MODE_RUN);
        request(5'b00010);
        expect_mode(MODE_LP_RUN);
        check("lp_main", 16'(ctrl.main_regulator_mode), 16'h0000);
        check("lp_flash", 16'(ctrl.flash_on), 16'h0000);
        check("lp_slow", 16'(ctrl.slow_osc_on), 16'h0001);
        wake_pulse(4'b1000);
        expect_mode(MODE_LP_RUN);
        request(5'b01000);
        expect_mode(MODE_LP_WAIT);
        check("lpw_cpu", 16'(ctrl.cpu_clock_on), 16'h0000);
        wake_pulse(4'b1010);
        expect_mode(MODE_LP_WAIT);
        wake_pulse(4'b0100);
        expect_mode(MODE_LP_RUN);
        request(5'b00001);
        expect_mode(MODE_RUN);
        check("run_main", 16'(ctrl.main_regulator_mode), 16'h0001);
        request(5'b00010);
        write_reg(8'h00, 8'h1d);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 expect_mode(MODE_RUN);
        read_reg(8'h00, "monitor_rereset", 8'h00);
        read_reg(8'h01, "reference_rereset", 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
